// ### acc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package acc_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ACC_OFF_CTRL = 8'h00;
  localparam logic [7:0] ACC_OFF_ACCUM = 8'h04;
  localparam logic [7:0] ACC_OFF_CLKREF = 8'h08;
  localparam logic [7:0] ACC_OFF_CHAN = 8'h0C;
  localparam logic [7:0] ACC_OFF_CMD = 8'h10;
  localparam logic [7:0] ACC_OFF_EVT = 8'h14;
  localparam logic [7:0] ACC_OFF_INTMASK = 8'h18;
  localparam logic [7:0] ACC_OFF_INTSTAT = 8'h1C;
  localparam logic [7:0] ACC_OFF_RESULT = 8'h20;
  localparam logic [7:0] ACC_OFF_WINLO = 8'h24;
  localparam logic [7:0] ACC_OFF_WINHI = 8'h28;
  localparam logic [7:0] ACC_OFF_WINCTRL = 8'h2C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ACC_BIT_ENABLE = 0;
  localparam int ACC_BIT_CONT = 1;
  localparam int ACC_BIT_RES = 2;
  localparam int ACC_BIT_START = 0;
  localparam int ACC_BIT_EVSTART = 0;
  localparam int ACC_BIT_RDY = 0;
  localparam int ACC_BIT_WCMP = 1;
  localparam int ACC_POS_REF = 4;
  localparam int ACC_POS_DLY = 4;
  localparam int ACC_POS_VAR = 8;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [1:0] ACC_REF_INTERNAL = 2'h0;
  localparam logic [2:0] ACC_RST_DIV = 3'h0;
  localparam int ACC_CONV_CYCLES = 13;
  localparam int ACC_MAX_ACCUM_LOG = 6;

  typedef enum logic [2:0] {
    WIN_NONE = 3'h0,
    WIN_BELOW = 3'h1,
    WIN_ABOVE = 3'h2,
    WIN_INSIDE = 3'h3,
    WIN_OUTSIDE = 3'h4
  } acc_win_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_GAP = 3'b100
  } acc_state_e;

  typedef struct packed {
    logic enable;
    logic cont;
    logic res8;
    logic ev_start;
  } acc_cfg_s;

endpackage

// ### acc_conv_ctrl.sv
// Purpose: digital control of a 10-bit successive-approximation converter
// Assumes: analog core samples on SAMPLE_STROBE, delivers bits on SAR_DATA at conversion end
// Notes: one clock domain, AXI4-Lite slave, level interrupt output
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module acc_conv_ctrl (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // axi4-lite write
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // event and touch controller
  input wire logic START_EVENT,
  input wire logic TOUCH_ENABLE,
  input wire logic TOUCH_START,
  input wire logic [4:0] TOUCH_CHANNEL,
  // analog core
  input wire logic [9:0] SAR_DATA,
  output logic CONV_CLK,
  output logic SAMPLE_STROBE,
  output logic [4:0] INPUT_CHANNEL_SELECT,
  output logic [1:0] REFERENCE_SELECT,
  output logic ANALOG_ENABLE,
  // interrupt
  output logic IRQ
);
  import acc_pkg::*;

  // ****************************************
  // register storage
  // ****************************************
  acc_cfg_s cfg_ff;
  logic [2:0] accumulate_count_ff;
  logic [3:0] sample_delay_ff;
  logic variation_ff;
  logic [2:0] clock_divider_ff;
  logic [1:0] reference_select_ff;
  logic [4:0] input_channel_select_ff;
  logic start_ff;
  logic [1:0] irq_mask_ff;
  logic [1:0] irq_stat_ff;
  logic [15:0] result_ff;
  logic [15:0] win_lo_ff;
  logic [15:0] win_hi_ff;
  acc_win_e win_mode_ff;
  acc_state_e state_ff;

  // merge strobed bytes over old; called with zero, so unstrobed register bytes write as 0
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) old[i*8 +: 8] = d[i*8 +: 8];
    end
    return old;
  endfunction

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic aw_held_ff, w_held_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_go, rd_go;
  logic [31:0] wd;
  logic [31:0] rd_val;
  logic rd_hit;

  assign AWREADY = !aw_held_ff && !BVALID;
  assign WREADY = !w_held_ff && !BVALID;
  assign ARREADY = !RVALID;
  assign wr_go = aw_held_ff && w_held_ff && !BVALID;
  assign rd_go = ARVALID && ARREADY;
  assign wd = merge(32'h0000_0000, w_data_ff, w_strb_ff);

  // address and data captured in either order
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= 2'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_ff <= 1'b1;
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (aw_addr_ff > ACC_OFF_WINCTRL || aw_addr_ff[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // read mux of the mapped words
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (ARADDR)
      ACC_OFF_CTRL: rd_val = {29'h0, cfg_ff.res8, cfg_ff.cont, cfg_ff.enable};
      ACC_OFF_ACCUM: rd_val = {23'h0, variation_ff, sample_delay_ff, 1'b0, accumulate_count_ff};
      ACC_OFF_CLKREF: rd_val = {26'h0, reference_select_ff, 1'b0, clock_divider_ff};
      ACC_OFF_CHAN: rd_val = {27'h0, input_channel_select_ff};
      ACC_OFF_CMD: rd_val = {31'h0, start_ff};
      ACC_OFF_EVT: rd_val = {31'h0, cfg_ff.ev_start};
      ACC_OFF_INTMASK: rd_val = {30'h0, irq_mask_ff};
      ACC_OFF_INTSTAT: rd_val = {30'h0, irq_stat_ff};
      ACC_OFF_RESULT: rd_val = {16'h0, result_ff};
      ACC_OFF_WINLO: rd_val = {16'h0, win_lo_ff};
      ACC_OFF_WINHI: rd_val = {16'h0, win_hi_ff};
      ACC_OFF_WINCTRL: rd_val = {29'h0, win_mode_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // read answer one cycle after address
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= 2'h0;
    end else if (rd_go) begin
      RVALID <= 1'b1;
      RDATA <= rd_val;
      RRESP <= rd_hit ? 2'h0 : 2'h2;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  logic wr_cmd, wr_stat, res_read;
  assign wr_cmd = wr_go && aw_addr_ff == ACC_OFF_CMD && wd[ACC_BIT_START];
  assign wr_stat = wr_go && aw_addr_ff == ACC_OFF_INTSTAT;
  assign res_read = rd_go && ARADDR == ACC_OFF_RESULT;

  // configuration words
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cfg_ff <= '0;
      accumulate_count_ff <= 3'h0;
      sample_delay_ff <= 4'h0;
      variation_ff <= 1'b0;
      clock_divider_ff <= ACC_RST_DIV;
      reference_select_ff <= ACC_REF_INTERNAL;
      input_channel_select_ff <= 5'h00;
      irq_mask_ff <= 2'h0;
      win_lo_ff <= 16'h0000;
      win_hi_ff <= 16'h0000;
      win_mode_ff <= WIN_NONE;
    end else if (wr_go) begin
      case (aw_addr_ff)
        ACC_OFF_CTRL: begin
          cfg_ff.enable <= wd[ACC_BIT_ENABLE];
          cfg_ff.cont <= wd[ACC_BIT_CONT];
          cfg_ff.res8 <= wd[ACC_BIT_RES];
        end
        ACC_OFF_ACCUM: begin
          accumulate_count_ff <= (wd[2:0] > 3'(ACC_MAX_ACCUM_LOG)) ? 3'(ACC_MAX_ACCUM_LOG)
                                                                  : wd[2:0];
          sample_delay_ff <= wd[ACC_POS_DLY +: 4];
          variation_ff <= wd[ACC_POS_VAR];
        end
        ACC_OFF_CLKREF: begin
          clock_divider_ff <= wd[2:0];
          reference_select_ff <= wd[ACC_POS_REF +: 2];
        end
        ACC_OFF_CHAN: input_channel_select_ff <= wd[4:0];
        ACC_OFF_EVT: cfg_ff.ev_start <= wd[ACC_BIT_EVSTART];
        ACC_OFF_INTMASK: irq_mask_ff <= wd[1:0];
        ACC_OFF_WINLO: win_lo_ff <= wd[15:0];
        ACC_OFF_WINHI: win_hi_ff <= wd[15:0];
        ACC_OFF_WINCTRL: win_mode_ff <= acc_win_e'(wd[2:0]);
        default: ;
      endcase
    end
  end

  // ****************************************
  // triggers and prescaler
  // ****************************************
  logic ev_s1_ff, ev_s2_ff, ev_s3_ff, ts_s1_ff, ts_s2_ff, te_s1_ff, te_s2_ff;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      {ev_s1_ff, ev_s2_ff, ev_s3_ff} <= 3'h0;
      {ts_s1_ff, ts_s2_ff, te_s1_ff, te_s2_ff} <= 4'h0;
    end else begin
      ev_s1_ff <= START_EVENT;
      ev_s2_ff <= ev_s1_ff;
      ev_s3_ff <= ev_s2_ff;
      ts_s1_ff <= TOUCH_START;
      ts_s2_ff <= ts_s1_ff;
      te_s1_ff <= TOUCH_ENABLE;
      te_s2_ff <= te_s1_ff;
    end
  end

  logic enabled, trigger, busy;
  assign enabled = cfg_ff.enable || te_s2_ff;
  // touch controller owns the trigger path while it is enabled
  assign trigger = te_s2_ff ? ts_s2_ff
                 : (wr_cmd || (cfg_ff.ev_start && ev_s2_ff && !ev_s3_ff));
  assign busy = state_ff != ST_IDLE;

  // divider held at zero when idle so start delay stays fixed
  logic [7:0] pre_ff;
  logic [7:0] half;
  logic tick;
  assign half = 8'(1) << clock_divider_ff;
  assign tick = pre_ff == half - 8'h01 && CONV_CLK;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pre_ff <= 8'h00;
      CONV_CLK <= 1'b0;
    end else if (!enabled || !busy) begin
      pre_ff <= 8'h00;
      CONV_CLK <= 1'b0;
    end else if (pre_ff == half - 8'h01) begin
      pre_ff <= 8'h00;
      CONV_CLK <= !CONV_CLK;
    end else begin
      pre_ff <= pre_ff + 8'h01;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  logic [3:0] cyc_ff;
  logic [6:0] smp_ff;
  logic [15:0] acc_ff;
  logic [7:0] lfsr_ff;
  logic [4:0] gap_ff;
  logic [9:0] sample;
  logic last_cyc, last_smp, done;
  assign sample = cfg_ff.res8 ? {2'h0, SAR_DATA[9:2]} : SAR_DATA;
  assign last_cyc = tick && cyc_ff == 4'(ACC_CONV_CYCLES - 1);
  assign last_smp = smp_ff == (7'(1) << accumulate_count_ff) - 7'h01;
  assign done = state_ff == ST_CONV && last_cyc && last_smp;
  assign SAMPLE_STROBE = state_ff == ST_CONV && tick && cyc_ff == 4'h1;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_ff <= ST_IDLE;
      cyc_ff <= 4'h0;
      smp_ff <= 7'h00;
      acc_ff <= 16'h0000;
      gap_ff <= 5'h00;
      start_ff <= 1'b0;
      result_ff <= 16'h0000;
      lfsr_ff <= 8'h01;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      if (!enabled) begin
        state_ff <= ST_IDLE;
        start_ff <= 1'b0;
        acc_ff <= 16'h0000;
        smp_ff <= 7'h00;
        cyc_ff <= 4'h0;
      end else begin
        case (state_ff)
          ST_IDLE: if (trigger) begin
            state_ff <= ST_CONV;
            start_ff <= 1'b1;
            cyc_ff <= 4'h0;
            smp_ff <= 7'h00;
            acc_ff <= 16'h0000;
          end
          ST_CONV: if (tick) begin
            cyc_ff <= cyc_ff + 4'h1;
            if (last_cyc) begin
              cyc_ff <= 4'h0;
              if (last_smp) begin
                result_ff <= acc_ff + {6'h00, sample};
                acc_ff <= 16'h0000;
                smp_ff <= 7'h00;
                start_ff <= cfg_ff.cont && !te_s2_ff;
                state_ff <= (cfg_ff.cont && !te_s2_ff) ? ST_CONV : ST_IDLE;
              end else begin
                acc_ff <= acc_ff + {6'h00, sample};
                smp_ff <= smp_ff + 7'h01;
                // small random stretch avoids locking onto noise harmonics
                gap_ff <= {1'b0, sample_delay_ff} + (variation_ff ? {3'h0, lfsr_ff[1:0]}
                                                                  : 5'h00);
                state_ff <= ST_GAP;
              end
            end
          end
          ST_GAP: if (tick) begin
            if (gap_ff == 5'h00) state_ff <= ST_CONV;
            else gap_ff <= gap_ff - 5'h01;
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // analog selections and interrupts
  // ****************************************
  // touch controller steers the channel outright; register picks wait for a safe point
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      INPUT_CHANNEL_SELECT <= 5'h00;
      REFERENCE_SELECT <= ACC_REF_INTERNAL;
      ANALOG_ENABLE <= 1'b0;
    end else begin
      ANALOG_ENABLE <= enabled;
      if (te_s2_ff) begin
        INPUT_CHANNEL_SELECT <= TOUCH_CHANNEL;
      end else if (enabled && (!busy || done)) begin
        INPUT_CHANNEL_SELECT <= input_channel_select_ff;
        REFERENCE_SELECT <= reference_select_ff;
      end
    end
  end

  logic [15:0] newres;
  logic win_hit;
  assign newres = acc_ff + {6'h00, sample};
  always_comb begin
    case (win_mode_ff)
      WIN_BELOW: win_hit = newres < win_lo_ff;
      WIN_ABOVE: win_hit = newres > win_hi_ff;
      WIN_INSIDE: win_hit = newres >= win_lo_ff && newres <= win_hi_ff;
      WIN_OUTSIDE: win_hit = newres < win_lo_ff || newres > win_hi_ff;
      default: win_hit = 1'b0;
    endcase
  end

  // sticky flags, set beats clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_stat_ff <= 2'h0;
    end else begin
      if (wr_stat) irq_stat_ff <= irq_stat_ff & ~wd[1:0];
      if (res_read) irq_stat_ff[ACC_BIT_RDY] <= 1'b0;
      if (done) irq_stat_ff[ACC_BIT_RDY] <= 1'b1;
      if (done && win_hit) irq_stat_ff[ACC_BIT_WCMP] <= 1'b1;
    end
  end

  assign IRQ = |(irq_stat_ff & irq_mask_ff);
endmodule

`default_nettype wire

// ### acc_props.sv
// Purpose: port-level checks for the converter control block
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to acc_conv_ctrl at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module acc_props
  import acc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  // converter side
  input wire logic TOUCH_ENABLE,
  input wire logic [4:0] TOUCH_CHANNEL,
  input wire logic CONV_CLK,
  input wire logic SAMPLE_STROBE,
  input wire logic [4:0] INPUT_CHANNEL_SELECT,
  input wire logic [1:0] REFERENCE_SELECT,
  input wire logic ANALOG_ENABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // ****************************************
  // bus answers
  // ****************************************
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer missing");
  a_read_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  a_write_holds: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped early");
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("write response missing");
  a_busy_refuse: assert property (BVALID |-> !AWREADY && !WREADY && !(RVALID && ARREADY))
    else $error("request taken while busy");

  // ****************************************
  // converter control
  // ****************************************
  a_ref_reset: assert property ($fell(RESET) |-> REFERENCE_SELECT == ACC_REF_INTERNAL)
    else $error("reference not internal after reset");
  // selections must not creep to the converter while disabled
  a_sel_frozen: assert property (!ANALOG_ENABLE && !TOUCH_ENABLE ##1 !ANALOG_ENABLE
    |-> $stable(INPUT_CHANNEL_SELECT) && $stable(REFERENCE_SELECT))
    else $error("selection changed while disabled");
  a_strobe_enabled: assert property (SAMPLE_STROBE || CONV_CLK |-> ANALOG_ENABLE)
    else $error("converter active while disabled");
  a_touch_owns: assert property ((TOUCH_ENABLE && $stable(TOUCH_CHANNEL)) [*6]
    |-> INPUT_CHANNEL_SELECT == TOUCH_CHANNEL)
    else $error("touch channel not applied");

  c_sample: cover property (SAMPLE_STROBE);
  c_conv_clk: cover property (ANALOG_ENABLE && CONV_CLK);
  c_read_done: cover property (RVALID && RREADY);
endmodule

bind acc_conv_ctrl acc_props i_acc_props (.CLK(CLK), .RESET(RESET), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .TOUCH_ENABLE(TOUCH_ENABLE), .TOUCH_CHANNEL(TOUCH_CHANNEL), .CONV_CLK(CONV_CLK),
  .SAMPLE_STROBE(SAMPLE_STROBE), .INPUT_CHANNEL_SELECT(INPUT_CHANNEL_SELECT),
  .REFERENCE_SELECT(REFERENCE_SELECT), .ANALOG_ENABLE(ANALOG_ENABLE));
`default_nettype wire

// ### acc_conv_ctrl_tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: bench is bus master, converter bits held per conversion
// Notes: fixed seed, polling bounded, readies raised late at random
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl_tb;
  import acc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, awr, wvl = 1'b0, wrd, bvl, brd = 1'b0;
  logic arv = 1'b0, arr, rvl, rrd = 1'b0, ev = 1'b0, ten = 1'b0, tst = 1'b0, cck, ssb, aen, irq;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, v;
  logic [1:0] bresp, rresp, refs, bq, rq;
  logic [4:0] tch = 5'h00, chs, c;
  logic [9:0] sar = 10'h000;
  int n_errors = 0, n_tests = 0, cyc = 0, t0, n, p, lo;
  int dv[4] = '{0, 1, 2, 0};
  int ac[4] = '{0, 2, 3, 6};
  int gp[4] = '{0, 0, 5, 0};
  int vr[4] = '{0, 0, 1, 0};
  int r8[4] = '{0, 1, 0, 0};

  acc_conv_ctrl i_acc_conv_ctrl (.CLK(clk), .RESET(rst), .AWADDR(awa), .AWVALID(awv),
    .AWREADY(awr), .WDATA(wd), .WSTRB(4'hF), .WVALID(wvl), .WREADY(wrd), .BRESP(bresp),
    .BVALID(bvl), .BREADY(brd), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvl), .RREADY(rrd), .START_EVENT(ev), .TOUCH_ENABLE(ten),
    .TOUCH_START(tst), .TOUCH_CHANNEL(tch), .SAR_DATA(sar), .CONV_CLK(cck),
    .SAMPLE_STROBE(ssb), .INPUT_CHANNEL_SELECT(chs), .REFERENCE_SELECT(refs),
    .ANALOG_ENABLE(aen), .IRQ(irq));

  // 250 MHz clock and a hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // readies sampled mid-cycle: inputs only move just after rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw, b;
    da = 1'b0;
    dw = 1'b0;
    b = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wvl <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      da |= awv && awr;
      dw |= wvl && wrd;
      @(posedge clk);
      if (da) awv <= 1'b0;
      if (dw) wvl <= 1'b0;
    end
    // late ready now and then, so held responses get exercised
    repeat ($urandom_range(2)) @(posedge clk);
    brd <= 1'b1;
    while (!b) begin
      @(negedge clk);
      b = bvl;
      bq = bresp;
      @(posedge clk);
    end
    brd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic b;
    b = 1'b0;
    ara <= a;
    arv <= 1'b1;
    while (!b) begin
      @(negedge clk);
      b = arr;
      @(posedge clk);
    end
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clk);
    rrd <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      b = rvl;
      d = rdata;
      rq = rresp;
      @(posedge clk);
    end
    rrd <= 1'b0;
  endtask

  task automatic wait_rdy;
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 1500 && s[0] !== 1'b1; i++) rd(ACC_OFF_INTSTAT, s);
    chk("ready flag", 32'h1, {31'h0, s[0]});
  endtask

  function automatic logic [31:0] expv(logic [9:0] s, int a, int r);
    return 32'(r ? s >> 2 : s) << a;
  endfunction

  function automatic logic hit(int m, int x);
    case (m)
      1: return x < 256;
      2: return x > 512;
      3: return x >= 256 && x <= 512;
      default: return x < 256 || x > 512;
    endcase
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(11604));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ACC_OFF_CLKREF, v);
    chk("clkref reset", 32'h0, v);
    chk("reference pins", 32'h0, {30'h0, refs});
    rd(8'h40, v);
    chk("unmapped read", 32'h2, {30'h0, rq});
    wr(8'h40, 32'h0);
    chk("unmapped write", 32'h2, {30'h0, bq});
    // selections held back until enable
    c = 5'(1 + $urandom_range(30));
    wr(ACC_OFF_CHAN, {27'h0, c});
    wr(ACC_OFF_CLKREF, 32'h10);
    chk("ref while off", 32'h0, {30'h0, refs});
    chk("chan while off", 32'h0, {27'h0, chs});
    wr(ACC_OFF_CTRL, 32'h1);
    rd(ACC_OFF_CTRL, v);
    chk("chan after enable", {27'h0, c}, {27'h0, chs});
    chk("ref after enable", 32'h1, {30'h0, refs});
    // single conversions over divider, count, gap and resolution
    for (int k = 0; k < 4; k++) begin
      sar <= 10'($urandom_range(1023));
      wr(ACC_OFF_CTRL, 32'h0);
      wr(ACC_OFF_ACCUM, 32'(ac[k] + (gp[k] << 4) + (vr[k] << 8)));
      wr(ACC_OFF_CLKREF, 32'(dv[k]));
      wr(ACC_OFF_INTMASK, 32'h1);
      wr(ACC_OFF_CTRL, 32'(1 + (r8[k] << 2)));
      t0 = cyc;
      wr(ACC_OFF_CMD, 32'h1);
      rd(ACC_OFF_CMD, v);
      chk("busy", 32'h1, v & 32'h1);
      wait_rdy();
      t0 = cyc - t0;
      n = 1 << ac[k];
      p = 2 << dv[k];
      lo = (13 * n + (n - 1) * gp[k]) * p;
      chk("duration", 32'h1, 32'(t0 >= lo && t0 <= lo + (3 * n + 2) * p + 60));
      chk("irq done", 32'h1, {31'h0, irq});
      rd(ACC_OFF_CMD, v);
      chk("start cleared", 32'h0, v & 32'h1);
      rd(ACC_OFF_RESULT, v);
      chk("result", expv(sar, ac[k], r8[k]), v);
      chk("irq after read", 32'h0, {31'h0, irq});
    end
    // window compare, all four modes
    wr(ACC_OFF_CTRL, 32'h0);
    wr(ACC_OFF_ACCUM, 32'h0);
    wr(ACC_OFF_WINLO, 32'h100);
    wr(ACC_OFF_WINHI, 32'h200);
    wr(ACC_OFF_INTMASK, 32'h2);
    wr(ACC_OFF_CTRL, 32'h1);
    for (int k = 0; k < 8; k++) begin
      sar <= ($urandom_range(2) == 0) ? 10'h050 : (($urandom_range(1) == 0) ? 10'h180 : 10'h300);
      wr(ACC_OFF_WINCTRL, 32'(1 + k % 4));
      wr(ACC_OFF_CMD, 32'h1);
      wait_rdy();
      rd(ACC_OFF_INTSTAT, v);
      chk("window hit", {30'h0, hit(1 + k % 4, sar), 1'b0}, v & 32'h2);
      chk("irq window", {31'h0, hit(1 + k % 4, sar)}, {31'h0, irq});
      wr(ACC_OFF_INTSTAT, 32'h3);
      rd(ACC_OFF_INTSTAT, v);
      chk("status cleared", 32'h0, v & 32'h3);
    end
    // continuous mode, then abort by disabling
    wr(ACC_OFF_WINCTRL, 32'h0);
    wr(ACC_OFF_CTRL, 32'h3);
    wr(ACC_OFF_CMD, 32'h1);
    wait_rdy();
    rd(ACC_OFF_RESULT, v);
    wait_rdy();
    rd(ACC_OFF_CMD, v);
    chk("still running", 32'h1, v & 32'h1);
    wr(ACC_OFF_CTRL, 32'h0);
    rd(ACC_OFF_CMD, v);
    chk("aborted", 32'h0, v & 32'h1);
    chk("analog off", 32'h0, {31'h0, aen});
    // event start, refused then accepted
    wr(ACC_OFF_INTSTAT, 32'h3);
    wr(ACC_OFF_CTRL, 32'h1);
    ev <= 1'b1;
    repeat (5) @(posedge clk);
    ev <= 1'b0;
    repeat (200) @(posedge clk);
    rd(ACC_OFF_INTSTAT, v);
    chk("no event start", 32'h0, v & 32'h1);
    wr(ACC_OFF_EVT, 32'h1);
    ev <= 1'b1;
    repeat (5) @(posedge clk);
    ev <= 1'b0;
    wait_rdy();
    // touch controller takes the channel
    tch <= c ^ 5'(1 + $urandom_range(30));
    ten <= 1'b1;
    repeat (10) @(posedge clk);
    chk("touch channel", {27'h0, tch}, {27'h0, chs});
    // register start is ignored while touch owns the converter
    wr(ACC_OFF_INTSTAT, 32'h3);
    wr(ACC_OFF_CMD, 32'h1);
    repeat (100) @(posedge clk);
    rd(ACC_OFF_INTSTAT, v);
    chk("start under touch", 32'h0, v & 32'h1);
    tst <= 1'b1;
    repeat (5) @(posedge clk);
    tst <= 1'b0;
    wait_rdy();
    stop_test();
  end
endmodule
`default_nettype wire
